// >>> src/swlc_phy.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - bits run back to back, each framed by two rising edges.
// - each bit is decoded against its own edge-delimited period.
// - slave switches current only while voltage is low, except slave resume.
// - link starts suspended at activation: voltage high, current low.
// - activated state exchanges bits until the master suspends.
// - deactivated means both signals low; left only by activation.
// - slave may transmit during the eight master resume idle bits.
// - slave resumes by drawing current; master answers within 5 us.
// - after slave resume, start flag within four bits of sequence end.
// - deactivated link returns only via the interface activation procedure.
// - either end may resume from suspended to activated.
// - idle bits are zero; at least one separates frames.
module swlc_phy (
    // system clock and reset
    input wire logic clock,
    input wire logic nrst,
    // link sampling clock
    input wire logic link_clk,
    // line
    input wire logic master_voltage_signal,
    output logic slave_current_signal,
    // receive stream
    output logic rx_valid,
    output logic rx_bit,
    // transmit stream
    input wire logic tx_valid,
    input wire logic tx_bit,
    output logic tx_ready,
    // slave resume
    input wire logic resume_req,
    output logic resume_timeout,
    output logic sof_deadline_miss,
    // status
    output swlc_pkg::swlc_state_type link_state,
    output logic suspend_idle_ok
);

    // ****************************************
    // link domain
    // ****************************************
    logic s1_l_meta_q, s1_l_q, s1_l_prev_q;
    logic [swlc_pkg::LCNT_W-1:0] hi_cnt_q, hi_cnt_d;
    logic [swlc_pkg::LCNT_W-1:0] per_cnt_q, per_cnt_d;
    logic bit_q, bit_d;
    logic bit_tgl_q, bit_tgl_d;
    logic s2_q, s2_d;
    logic tx_meta_q, tx_sync_q;
    logic res_meta_q, res_sync_q;
    logic l_rise, l_fall;
    logic tx_lvl_q;
    logic res_q;

    always_comb begin
        l_rise = s1_l_q & ~s1_l_prev_q;
        l_fall = ~s1_l_q & s1_l_prev_q;
        hi_cnt_d = hi_cnt_q;
        per_cnt_d = per_cnt_q;
        bit_d = bit_q;
        bit_tgl_d = bit_tgl_q;
        if (l_rise) begin
            bit_d = ({1'b0, hi_cnt_q, 1'b0} > {2'b00, per_cnt_q});
            bit_tgl_d = ~bit_tgl_q;
            hi_cnt_d = {{(swlc_pkg::LCNT_W-1){1'b0}}, 1'b1};
            per_cnt_d = {{(swlc_pkg::LCNT_W-1){1'b0}}, 1'b1};
        end else begin
            if (per_cnt_q != swlc_pkg::LCNT_MAX) begin
                per_cnt_d = per_cnt_q + 1'b1;
            end
            if (s1_l_q && hi_cnt_q != swlc_pkg::LCNT_MAX) begin
                hi_cnt_d = hi_cnt_q + 1'b1;
            end
        end
        // switch only at low phase, resume excepted
        if (res_sync_q) begin
            s2_d = 1'b1;
        end else if (l_fall) begin
            s2_d = tx_sync_q;
        end else begin
            s2_d = s2_q;
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            s1_l_meta_q <= 1'b0;
            s1_l_q <= 1'b0;
            s1_l_prev_q <= 1'b0;
            hi_cnt_q <= '0;
            per_cnt_q <= '0;
            bit_q <= 1'b0;
            bit_tgl_q <= 1'b0;
            s2_q <= 1'b0;
            tx_meta_q <= 1'b0;
            tx_sync_q <= 1'b0;
            res_meta_q <= 1'b0;
            res_sync_q <= 1'b0;
        end else begin
            s1_l_meta_q <= master_voltage_signal;
            s1_l_q <= s1_l_meta_q;
            s1_l_prev_q <= s1_l_q;
            hi_cnt_q <= hi_cnt_d;
            per_cnt_q <= per_cnt_d;
            bit_q <= bit_d;
            bit_tgl_q <= bit_tgl_d;
            s2_q <= s2_d;
            tx_meta_q <= tx_lvl_q;
            tx_sync_q <= tx_meta_q;
            res_meta_q <= res_q;
            res_sync_q <= res_meta_q;
        end
    end

    assign slave_current_signal = s2_q;

    // ****************************************
    // system domain
    // ****************************************
    logic s1_s_meta_q, s1_s_q, s1_s_prev_q, s1_s_dly_q;
    logic tgl_meta_q, tgl_s1_q, tgl_s2_q;
    swlc_pkg::swlc_state_type state_q, state_d;
    logic [swlc_pkg::TMR_W-1:0] tmr_q, tmr_d;
    logic [swlc_pkg::TMR_W-1:0] resp_q, resp_d;
    logic [swlc_pkg::BCNT_W-1:0] bcnt_q, bcnt_d;
    logic [2:0] idle_run_q, idle_run_d;
    logic res_d;
    logic tx_lvl_d;
    logic rx_valid_q, rx_valid_d;
    logic rx_bit_q, rx_bit_d;
    logic resume_to_q, resume_to_d;
    logic sof_miss_q, sof_miss_d;
    logic sof_wait_q, sof_wait_d;
    logic bit_evt, s_rise, s_fall, s_rise_late, streaming, accept;

    always_comb begin
        bit_evt = tgl_s1_q ^ tgl_s2_q;
        s_rise = s1_s_q & ~s1_s_prev_q;
        s_fall = ~s1_s_q & s1_s_prev_q;
        // one clock behind, so the bit event of this rise has gone by or falls in this same cycle
        s_rise_late = s1_s_prev_q & ~s1_s_dly_q;
        // bits flow while activated or resuming
        streaming = (state_q == swlc_pkg::SWLC_ACTIVATED) ||
                    (state_q == swlc_pkg::SWLC_RESUMING);
        accept = bit_evt & streaming;
        state_d = state_q;
        bcnt_d = bcnt_q;
        res_d = res_q;
        resp_d = resp_q;
        resume_to_d = 1'b0;
        sof_miss_d = 1'b0;
        sof_wait_d = sof_wait_q;
        rx_valid_d = 1'b0;
        rx_bit_d = rx_bit_q;
        idle_run_d = idle_run_q;
        tx_lvl_d = tx_lvl_q;
        if (s_rise || s_fall) begin
            tmr_d = '0;
        end else if (tmr_q != swlc_pkg::TMR_MAX) begin
            tmr_d = tmr_q + 1'b1;
        end else begin
            tmr_d = tmr_q;
        end
        unique case (state_q)
            swlc_pkg::SWLC_DEACTIVATED: begin
                res_d = 1'b0;
                sof_wait_d = 1'b0;
                if (s1_s_prev_q) begin
                    state_d = swlc_pkg::SWLC_SUSPENDED;
                end
            end
            swlc_pkg::SWLC_SUSPENDED: begin
                if (resume_req && !res_q && s1_s_q) begin
                    res_d = 1'b1;
                    resp_d = '0;
                end
                if (res_q && s1_s_q) begin
                    if (resp_q >= swlc_pkg::RESP_CYC) begin
                        res_d = 1'b0;
                        resume_to_d = 1'b1;
                    end else begin
                        resp_d = resp_q + 1'b1;
                    end
                end
                if (s_rise_late) begin
                    bcnt_d = '0;
                    if (res_q) begin
                        res_d = 1'b0;
                        sof_wait_d = 1'b1;
                        state_d = swlc_pkg::SWLC_ACTIVATED;
                    end else begin
                        state_d = swlc_pkg::SWLC_RESUMING;
                    end
                end
            end
            swlc_pkg::SWLC_RESUMING: begin
                if (bit_evt) begin
                    bcnt_d = bcnt_q + 1'b1;
                    if (bcnt_q == swlc_pkg::MASTER_RESUME_IDLE_COUNT - 1'b1) begin
                        state_d = swlc_pkg::SWLC_ACTIVATED;
                    end
                end
            end
            swlc_pkg::SWLC_ACTIVATED: begin
                if (s1_s_q && tmr_q > swlc_pkg::SUSP_CYC) begin
                    state_d = swlc_pkg::SWLC_SUSPENDED;
                    sof_wait_d = 1'b0;
                end
                if (sof_wait_q) begin
                    if (accept && tx_valid) begin
                        sof_wait_d = 1'b0;
                    end else if (bit_evt) begin
                        bcnt_d = bcnt_q + 1'b1;
                        if (bcnt_q == swlc_pkg::SOF_DELAY_BITS - 1'b1) begin
                            sof_miss_d = 1'b1;
                            sof_wait_d = 1'b0;
                        end
                    end
                end
            end
        endcase
        if (state_q != swlc_pkg::SWLC_DEACTIVATED && !s1_s_q &&
            tmr_q > swlc_pkg::DEACT_CYC) begin
            state_d = swlc_pkg::SWLC_DEACTIVATED;
            res_d = 1'b0;
            sof_wait_d = 1'b0;
        end
        if (accept) begin
            rx_valid_d = 1'b1;
            rx_bit_d = bit_q;
            tx_lvl_d = tx_valid ? tx_bit : 1'b0;
            if (bit_q) begin
                idle_run_d = '0;
            end else if (idle_run_q != swlc_pkg::SUSPEND_IDLE_COUNT) begin
                idle_run_d = idle_run_q + 1'b1;
            end
        end else if (!streaming) begin
            tx_lvl_d = 1'b0;
            idle_run_d = '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_s_meta_q <= 1'b0;
            s1_s_q <= 1'b0;
            s1_s_prev_q <= 1'b0;
            s1_s_dly_q <= 1'b0;
            tgl_meta_q <= 1'b0;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            state_q <= swlc_pkg::SWLC_DEACTIVATED;
            tmr_q <= '0;
            resp_q <= '0;
            bcnt_q <= '0;
            idle_run_q <= '0;
            res_q <= 1'b0;
            tx_lvl_q <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_bit_q <= 1'b0;
            resume_to_q <= 1'b0;
            sof_miss_q <= 1'b0;
            sof_wait_q <= 1'b0;
        end else begin
            s1_s_meta_q <= master_voltage_signal;
            s1_s_q <= s1_s_meta_q;
            s1_s_prev_q <= s1_s_q;
            s1_s_dly_q <= s1_s_prev_q;
            tgl_meta_q <= bit_tgl_q;
            tgl_s1_q <= tgl_meta_q;
            tgl_s2_q <= tgl_s1_q;
            state_q <= state_d;
            tmr_q <= tmr_d;
            resp_q <= resp_d;
            bcnt_q <= bcnt_d;
            idle_run_q <= idle_run_d;
            res_q <= res_d;
            tx_lvl_q <= tx_lvl_d;
            rx_valid_q <= rx_valid_d;
            rx_bit_q <= rx_bit_d;
            resume_to_q <= resume_to_d;
            sof_miss_q <= sof_miss_d;
            sof_wait_q <= sof_wait_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign tx_ready = accept;
    assign rx_valid = rx_valid_q;
    assign rx_bit = rx_bit_q;
    assign resume_timeout = resume_to_q;
    assign sof_deadline_miss = sof_miss_q;
    assign link_state = state_q;
    assign suspend_idle_ok = (idle_run_q == swlc_pkg::SUSPEND_IDLE_COUNT);

endmodule

`default_nettype wire

// >>> src/swlc_pkg.sv
// ****************************************
// constants for the single wire line coding
// ****************************************
package swlc_pkg;

    // link states
    typedef enum logic [1:0] {
        SWLC_DEACTIVATED,
        SWLC_SUSPENDED,
        SWLC_RESUMING,
        SWLC_ACTIVATED
    } swlc_state_type;

    // system clock rate
    localparam int CLK_MHZ = 40;

    // counter widths
    localparam int TMR_W = 13;
    localparam int LCNT_W = 16;
    localparam int BCNT_W = 4;

    // slave resume response time, longest
    localparam int SLAVE_RESUME_RESPONSE_TIME_US = 5;
    localparam logic [TMR_W-1:0] RESP_CYC = TMR_W'(SLAVE_RESUME_RESPONSE_TIME_US * CLK_MHZ);

    // deactivation low time, least
    localparam int DEACTIVATION_LOW_TIME_US = 100;
    localparam logic [TMR_W-1:0] DEACT_CYC = TMR_W'(DEACTIVATION_LOW_TIME_US * CLK_MHZ);

    // a high level longer than the longest bit period means suspend
    localparam int SUSPEND_HIGH_TIME_US = 10;
    localparam logic [TMR_W-1:0] SUSP_CYC = TMR_W'(SUSPEND_HIGH_TIME_US * CLK_MHZ);

    // bit counts
    localparam logic [BCNT_W-1:0] MASTER_RESUME_IDLE_COUNT = 4'h8;
    localparam logic [BCNT_W-1:0] SOF_DELAY_BITS = 4'h4;
    localparam logic [2:0] SUSPEND_IDLE_COUNT = 3'h7;

    // counter saturation values
    localparam logic [TMR_W-1:0] TMR_MAX = {TMR_W{1'b1}};
    localparam logic [LCNT_W-1:0] LCNT_MAX = {LCNT_W{1'b1}};

endpackage

// >>> tb/swlc_phy_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// link checker
// ********************
module swlc_chk (
    // clocks and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clk,
    // line
    input wire logic master_voltage_signal,
    input wire logic slave_current_signal,
    // outputs watched
    input wire logic rx_valid,
    input wire logic resume_timeout,
    input wire logic sof_deadline_miss,
    input wire swlc_pkg::swlc_state_type link_state
);
    logic [12:0] lo_q, lo_d, hi_q, hi_d;
    always_comb begin
        lo_d = master_voltage_signal ? 13'h0 : lo_q + 13'h1;
        hi_d = master_voltage_signal ? hi_q + 13'h1 : 13'h0;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lo_q <= 13'h0;
            hi_q <= 13'h0;
        end else begin
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end
    sequence s_deact;
        link_state == swlc_pkg::SWLC_DEACTIVATED;
    endsequence
    sequence s_left;
        s_deact ##1 link_state != swlc_pkg::SWLC_DEACTIVATED;
    endsequence
    property p_act;
        @(posedge clock) disable iff (!nrst) s_left |-> link_state == swlc_pkg::SWLC_SUSPENDED;
    endproperty
    a_act: assert property (p_act) else $error("activation not to suspended");
    property p_quiet;
        @(posedge clock) disable iff (!nrst) s_deact [*8] |-> !slave_current_signal;
    endproperty
    a_quiet: assert property (p_quiet) else $error("current while deactivated");
    property p_rx;
        @(posedge clock) disable iff (!nrst)
            rx_valid |-> link_state inside {swlc_pkg::SWLC_RESUMING, swlc_pkg::SWLC_ACTIVATED};
    endproperty
    a_rx: assert property (p_rx) else $error("bit out of streaming state");
    property p_deact;
        @(posedge clock) disable iff (!nrst) lo_q == 13'h1004 |-> s_deact;
    endproperty
    a_deact: assert property (p_deact) else $error("long low did not deactivate");
    property p_susp;
        @(posedge clock) disable iff (!nrst)
            hi_q == 13'h01c2 |-> link_state != swlc_pkg::SWLC_ACTIVATED;
    endproperty
    a_susp: assert property (p_susp) else $error("long high did not suspend");
    property p_tmo;
        @(posedge clock) disable iff (!nrst)
            resume_timeout |-> hi_q >= 13'h00c8 && link_state == swlc_pkg::SWLC_SUSPENDED;
    endproperty
    a_tmo: assert property (p_tmo) else $error("early resume timeout");
    property p_sof;
        @(posedge clock) disable iff (!nrst)
            sof_deadline_miss |-> link_state == swlc_pkg::SWLC_ACTIVATED;
    endproperty
    a_sof: assert property (p_sof) else $error("start flag miss out of activated");
    property p_cur;
        @(posedge link_clk) disable iff (!nrst)
            $fell(slave_current_signal) |-> !master_voltage_signal;
    endproperty
    a_cur: assert property (p_cur) else $error("current switched while high");
endmodule
bind swlc_phy swlc_chk u_chk (
    .clock(clock), .nrst(nrst), .link_clk(link_clk),
    .master_voltage_signal(master_voltage_signal), .slave_current_signal(slave_current_signal),
    .rx_valid(rx_valid), .resume_timeout(resume_timeout),
    .sof_deadline_miss(sof_deadline_miss), .link_state(link_state)
);
`default_nettype wire

// >>> tb/swlc_master.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// front end master model
// ********************
module swlc_master (
    // line
    output logic master_voltage_signal,
    input wire logic slave_current_signal
);
    logic seen;
    initial begin
        master_voltage_signal = 1'b0;
        seen = 1'b0;
    end
    task automatic send_bit(input logic v, input int t_ns);
        master_voltage_signal = 1'b1;
        #(v ? t_ns * 3 / 4 : t_ns / 4);
        seen = slave_current_signal;
        master_voltage_signal = 1'b0;
        #(v ? t_ns / 4 : t_ns * 3 / 4);
    endtask
    task automatic hold(input logic lvl, input int t_ns);
        master_voltage_signal = lvl;
        #(t_ns);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// link testbench
// ********************
module tb;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_bit = 1'b0;
    logic resume_req = 1'b0;
    logic mvs, cur, rx_valid, rx_bit, r_to, s_miss, idle_ok, rdy;
    swlc_pkg::swlc_state_type st;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_to = 0;
    int n_miss = 0;
    int n_rdy = 0;
    int n_rx = 0;
    always #12.5 clock = ~clock;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    swlc_phy u_dut (
        .clock(clock), .nrst(nrst), .link_clk(link_clk),
        .master_voltage_signal(mvs), .slave_current_signal(cur),
        .rx_valid(rx_valid), .rx_bit(rx_bit), .tx_valid(tx_valid), .tx_bit(tx_bit),
        .tx_ready(rdy), .resume_req(resume_req), .resume_timeout(r_to),
        .sof_deadline_miss(s_miss), .link_state(st), .suspend_idle_ok(idle_ok)
    );
    swlc_master u_mst (.master_voltage_signal(mvs), .slave_current_signal(cur));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (r_to === 1'b1) n_to <= n_to + 1;
        if (s_miss === 1'b1) n_miss <= n_miss + 1;
        if (rdy === 1'b1) n_rdy <= n_rdy + 1;
        if (rx_valid === 1'b1) n_rx <= n_rx + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse_req();
        @(posedge clock);
        resume_req <= 1'b1;
        @(posedge clock);
        resume_req <= 1'b0;
        repeat (10) @(posedge clock);
        #1;
    endtask
    task automatic t_start();
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        #1;
        chk(st, swlc_pkg::SWLC_DEACTIVATED);
        u_mst.hold(1'b1, 2000);
        chk(st, swlc_pkg::SWLC_SUSPENDED);
        chk(2'(cur), 2'h0);
        $display("test start done");
    endtask
    task automatic t_master_resume();
        u_mst.hold(1'b0, 1000);
        for (int i = 0; i < 8; i++) u_mst.send_bit(1'b0, 1000 + 500 * i);
        chk(st, swlc_pkg::SWLC_RESUMING);
        u_mst.send_bit(1'b0, 2000);
        chk(st, swlc_pkg::SWLC_ACTIVATED);
        $display("test master resume done");
    endtask
    task automatic t_stream();
        logic [5:0] pat;
        int n0;
        int m0;
        pat = 6'h2d;
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_bit <= 1'b1;
        n0 = n_rdy;
        m0 = n_rx;
        for (int i = 0; i < 6; i++) begin
            u_mst.send_bit(pat[i], 600 + 1800 * i);
            if (i > 0) chk(2'(rx_bit), 2'(pat[i-1]));
            if (i > 1) chk(2'(u_mst.seen), 2'h1);
        end
        chk(n_rdy - n0, 32'h6);
        chk(n_rx - m0, 32'h6);
        @(posedge clock);
        tx_valid <= 1'b0;
        for (int i = 0; i < 8; i++) u_mst.send_bit(1'b0, 2000);
        chk(2'(u_mst.seen), 2'h0);
        chk(2'(idle_ok), 2'h1);
        u_mst.hold(1'b1, 12000);
        chk(st, swlc_pkg::SWLC_SUSPENDED);
        $display("test stream done");
    endtask
    task automatic t_slave_resume();
        pulse_req();
        chk(2'(cur), 2'h1);
        u_mst.hold(1'b0, 1000);
        u_mst.send_bit(1'b0, 2000);
        chk(st, swlc_pkg::SWLC_ACTIVATED);
        for (int i = 0; i < 5; i++) u_mst.send_bit(1'b0, 2000);
        chk(n_miss, 32'h1);
        u_mst.hold(1'b1, 12000);
        pulse_req();
        u_mst.hold(1'b1, 8000);
        chk(n_to, 32'h1);
        $display("test slave resume done");
    endtask
    task automatic t_deact();
        u_mst.hold(1'b0, 110000); // deactivate then activate
        chk(st, swlc_pkg::SWLC_DEACTIVATED);
        chk(2'(cur), 2'h0);
        u_mst.hold(1'b1, 2000);
        chk(st, swlc_pkg::SWLC_SUSPENDED);
        $display("test deactivate done");
    endtask
    initial begin
        t_start();
        t_master_resume();
        t_stream();
        t_slave_resume();
        t_deact();
        final_report();
    end
endmodule
`default_nettype wire
